// [hw/lgpc_pkg.sv]
// Purpose: Shared constants and types for the lighting gateway panel control.
// Assumes: 125 MHz system clock, synchronous active-high reset.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`default_nettype none
package lgpc_pkg;
  // ==========================================================================
  // Clock and time
  localparam longint unsigned CLK_HZ        = 125_000_000;
  localparam longint unsigned DEBOUNCE_MS   = 20;
  localparam longint unsigned SHORT_MS      = 2000;   // 2 s threshold
  localparam longint unsigned LONG_MS       = 5000;   // 5 s threshold
  localparam longint unsigned IDLE_MIN      = 5;      // Test mode idle limit
  localparam longint unsigned SLOW_HZ       = 1;
  localparam longint unsigned FAST_HZ       = 10;
  localparam longint unsigned DEBOUNCE_CYC  = (CLK_HZ * DEBOUNCE_MS + 999) / 1000;
  localparam longint unsigned SHORT_CYC     = (CLK_HZ * SHORT_MS + 999) / 1000;
  localparam longint unsigned LONG_CYC      = (CLK_HZ * LONG_MS + 999) / 1000;
  localparam longint unsigned IDLE_CYC      = CLK_HZ * 60 * IDLE_MIN;
  localparam longint unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam longint unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
  localparam int              CNT_W         = 40;

  // ==========================================================================
  // Lighting bus addressing
  localparam int              CHANNELS      = 2;
  localparam int              ADDR_W        = 6;
  localparam logic [6:0]      MAX_DEVICES   = 7'h40;  // 64 per channel
  localparam logic [6:0]      NO_FREE_ADDR  = 7'h40;

  // ==========================================================================
  // Factory building-bus address, area.line.device
  localparam logic [3:0]      FACT_AREA     = 4'hF;
  localparam logic [3:0]      FACT_LINE     = 4'hF;
  localparam logic [7:0]      FACT_DEV      = 8'hFF;
  localparam logic [15:0]     FACT_PHYS     = {FACT_AREA, FACT_LINE, FACT_DEV};

  typedef enum logic {LGPC_MODE_NORMAL, LGPC_MODE_TEST} lgpc_mode_e;
endpackage
`default_nettype wire

// [hw/lgpc_blinker.sv]
// Purpose: Square-wave LED flasher with a fixed half period.
// Assumes: Half period of at least one cycle.
// Notes:   Output starts lit on enable so a blink is visible at once.
`timescale 1ns/1ns
`default_nettype none
module lgpc_blinker
  import lgpc_pkg::*;
#(
  parameter longint unsigned HALF_CYC = FAST_HALF_CYC
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic en_in,
  output logic      blink_out
);
  logic [CNT_W-1:0] cnt_reg;

  // ==========================================================================
  // Half-period counter and toggle
  always_ff @(posedge clk_in) begin
    if (srst_in || !en_in) begin
      // Parked at terminal count so the first enabled edge lights the LED
      cnt_reg   <= CNT_W'(HALF_CYC - 1);
      blink_out <= 1'b0;
    end else if (cnt_reg == CNT_W'(HALF_CYC - 1)) begin
      // Restart from zero so each phase lasts exactly HALF_CYC cycles
      cnt_reg   <= '0;
      blink_out <= !blink_out;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// [hw/lgpc_press_timer.sv]
// Purpose: Debounce a push button and classify each press by its length.
// Assumes: Button input synchronous to clk_in, high while pressed.
// Notes:   Short and mid decisions fall on release; long fires while held.
`timescale 1ns/1ns
`default_nettype none
module lgpc_press_timer
  import lgpc_pkg::*;
#(
  parameter longint unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter longint unsigned SHORT_LIM = SHORT_CYC,
  parameter longint unsigned LONG_LIM  = LONG_CYC
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic btn_in,
  output logic      press_out,
  output logic      short_out,
  output logic      mid_out,
  output logic      long_out
);
  logic             stable_reg;
  logic [CNT_W-1:0] deb_reg;
  logic [CNT_W-1:0] dur_reg;

  // ==========================================================================
  // Debounce: adopt a new level only after it held for DEB_CYC
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      stable_reg <= 1'b0;
      deb_reg    <= '0;
    end else if (btn_in == stable_reg) begin
      deb_reg <= '0;
    end else if (deb_reg == CNT_W'(DEB_CYC - 1)) begin
      deb_reg    <= '0;
      stable_reg <= btn_in;
    end else begin
      deb_reg <= deb_reg + CNT_W'(1);
    end
  end

  // ==========================================================================
  // Duration count on the clean level, saturating at the long limit
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dur_reg   <= '0;
      press_out <= 1'b0;
      short_out <= 1'b0;
      mid_out   <= 1'b0;
      long_out  <= 1'b0;
    end else begin
      press_out <= 1'b0;
      short_out <= 1'b0;
      mid_out   <= 1'b0;
      long_out  <= 1'b0;
      if (stable_reg) begin
        if (dur_reg == '0)
          press_out <= 1'b1;
        if (dur_reg == CNT_W'(LONG_LIM - 1))
          long_out <= 1'b1;
        if (dur_reg != CNT_W'(LONG_LIM))
          dur_reg <= dur_reg + CNT_W'(1);
      end else if (dur_reg != '0) begin
        // Release: a long press already reported while held
        short_out <= dur_reg < CNT_W'(SHORT_LIM);
        mid_out   <= dur_reg >= CNT_W'(SHORT_LIM) && dur_reg < CNT_W'(LONG_LIM);
        dur_reg   <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/lgpc_panel_ctrl.sv]
// Purpose: Front-panel supervision of a two-channel lighting gateway:
//          programming LED, ready and status LEDs, test mode, init phase
//          and short-address allocation.
// Assumes: All inputs synchronous to clk_in; the scan engine reports
//          addressed devices before unaddressed ones in each init scan.
// Notes:   Long timers are parameters so simulation can shorten them.
`timescale 1ns/1ns
`default_nettype none
module lgpc_panel_ctrl
  import lgpc_pkg::*;
#(
  parameter longint unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter longint unsigned SHORT_LIM = SHORT_CYC,
  parameter longint unsigned LONG_LIM  = LONG_CYC,
  parameter longint unsigned IDLE_LIM  = IDLE_CYC,
  parameter longint unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter longint unsigned FAST_HALF = FAST_HALF_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              prog_btn_in,
  input  wire logic              phys_set_in,
  input  wire logic [15:0]       phys_addr_in,
  input  wire logic              supply_ok_in,
  input  wire logic              fault_short_in,
  input  wire logic              fault_ballast_in,
  input  wire logic              fault_lamp_in,
  input  wire logic              test_btn_in,
  input  wire logic              download_in,
  input  wire logic              bus_recover_in,
  input  wire logic              count_cmd_in,
  input  wire logic              auto_addr_en_in,
  input  wire logic              dev_valid_in,
  input  wire logic              dev_chan_in,
  input  wire logic              dev_has_addr_in,
  input  wire logic [ADDR_W-1:0] dev_addr_in,
  input  wire logic              scan_done_in,
  output logic                   prog_led_out,
  output logic [15:0]            phys_addr_out,
  output logic                   ready_led_out,
  output logic                   status_led_out,
  output logic                   test_mode_out,
  output logic                   chan_a_on_out,
  output logic                   chan_b_on_out,
  output logic                   discard_levels_out,
  output logic                   init_active_out,
  output logic                   init_start_out,
  output logic                   count_req_out,
  output logic [7:0]             ref_count_out,
  output logic                   dev_ready_out,
  output logic                   assign_valid_out,
  output logic                   assign_chan_out,
  output logic [ADDR_W-1:0]      assign_addr_out,
  output logic [6:0]             assign_dev_out
);
  // ==========================================================================
  // Helpers
  function automatic logic [6:0] lowest_free(input logic [63:0] map);
    logic [6:0] r;
    r = NO_FREE_ADDR;
    for (int i = 63; i >= 0; i--)
      if (!map[i])
        r = 7'(i);
    return r;
  endfunction

  function automatic logic [6:0] dev_number(input logic [ADDR_W-1:0] a);
    return {1'b0, a} + 7'h01;
  endfunction

  lgpc_mode_e       mode_reg;
  logic             prog_btn_d_reg;
  logic             short_d_reg;
  logic             overflow_reg;
  logic             counting_reg;
  logic [CNT_W-1:0] idle_reg;
  logic [63:0]      used_reg [CHANNELS];
  logic [6:0]       chan_cnt_reg [CHANNELS];
  logic [7:0]       total_reg;
  logic [6:0]       free_addr;
  logic             press_p, short_p, mid_p, long_p;
  logic             slow_blink, fast_blink;
  logic             test_enter, test_leave, init_go, idle_hit;

  lgpc_press_timer #(
    .DEB_CYC   (DEB_CYC),
    .SHORT_LIM (SHORT_LIM),
    .LONG_LIM  (LONG_LIM)
  ) u_press (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .btn_in    (test_btn_in),
    .press_out (press_p),
    .short_out (short_p),
    .mid_out   (mid_p),
    .long_out  (long_p)
  );

  lgpc_blinker #(.HALF_CYC(SLOW_HALF)) u_slow (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .en_in     (mode_reg == LGPC_MODE_TEST),
    .blink_out (slow_blink)
  );

  lgpc_blinker #(.HALF_CYC(FAST_HALF)) u_fast (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .en_in     (init_active_out),
    .blink_out (fast_blink)
  );

  // ==========================================================================
  // Programming mode; independent of supply so the bus can always program
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prog_btn_d_reg <= 1'b0;
      prog_led_out   <= 1'b0;
      phys_addr_out  <= FACT_PHYS;
    end else begin
      prog_btn_d_reg <= prog_btn_in;
      if (phys_set_in && prog_led_out)
        phys_addr_out <= phys_addr_in;
      if (prog_btn_in && !prog_btn_d_reg)
        prog_led_out <= !prog_led_out;
      else if (phys_set_in)
        prog_led_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Test mode decisions
  assign idle_hit   = mode_reg == LGPC_MODE_TEST && idle_reg == CNT_W'(IDLE_LIM - 1);
  assign test_enter = mode_reg == LGPC_MODE_NORMAL && mid_p;
  assign test_leave = mode_reg == LGPC_MODE_TEST && (mid_p || bus_recover_in || idle_hit);
  assign init_go    = download_in || bus_recover_in || test_leave
                      || (short_d_reg && !fault_short_in);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_reg           <= LGPC_MODE_NORMAL;
      chan_a_on_out      <= 1'b0;
      chan_b_on_out      <= 1'b0;
      discard_levels_out <= 1'b0;
    end else begin
      discard_levels_out <= test_enter;
      if (test_enter) begin
        mode_reg      <= LGPC_MODE_TEST;
        chan_a_on_out <= 1'b1;
        chan_b_on_out <= 1'b0;
      end else if (test_leave) begin
        mode_reg <= LGPC_MODE_NORMAL;
      end else if (mode_reg == LGPC_MODE_TEST && short_p) begin
        chan_a_on_out <= !chan_a_on_out;
        chan_b_on_out <= !chan_b_on_out;
      end
    end
  end
  assign test_mode_out = mode_reg == LGPC_MODE_TEST;

  // Idle timer; brightness outputs are left as they stand on timeout
  always_ff @(posedge clk_in) begin
    if (srst_in || mode_reg != LGPC_MODE_TEST || test_leave || press_p)
      idle_reg <= '0;
    else
      idle_reg <= idle_reg + CNT_W'(1);
  end

  // ==========================================================================
  // Init phase and device counting sessions
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      init_active_out <= 1'b0;
      init_start_out  <= 1'b0;
      short_d_reg     <= 1'b0;
      counting_reg    <= 1'b0;
      count_req_out   <= 1'b0;
      ref_count_out   <= 8'h00;
      total_reg       <= 8'h00;
    end else begin
      short_d_reg    <= fault_short_in;
      init_start_out <= init_go;
      count_req_out  <= (long_p || count_cmd_in) && !counting_reg;
      if (init_go)
        init_active_out <= 1'b1;
      else if (scan_done_in && !overflow_reg)
        init_active_out <= 1'b0;
      if ((long_p || count_cmd_in) && !counting_reg) begin
        counting_reg <= 1'b1;
        total_reg    <= 8'h00;
      end else if (counting_reg && scan_done_in) begin
        counting_reg  <= 1'b0;
        ref_count_out <= total_reg;
      end else if (counting_reg && dev_valid_in && total_reg != 8'hFF) begin
        total_reg <= total_reg + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Short-address allocation, one reported device per cycle
  assign dev_ready_out = 1'b1;

  // Lowest free address on the reporting channel, from the map as it stands
  assign free_addr = lowest_free(used_reg[dev_chan_in]);

  always_ff @(posedge clk_in) begin
    if (srst_in || init_go) begin
      for (int c = 0; c < CHANNELS; c++) begin
        used_reg[c]     <= 64'h0;
        chan_cnt_reg[c] <= 7'h00;
      end
      overflow_reg     <= 1'b0;
      assign_valid_out <= 1'b0;
      assign_chan_out  <= 1'b0;
      assign_addr_out  <= '0;
      assign_dev_out   <= 7'h00;
    end else begin
      assign_valid_out <= 1'b0;
      if (init_active_out && !counting_reg && dev_valid_in) begin
        if (chan_cnt_reg[dev_chan_in] == MAX_DEVICES)
          overflow_reg <= 1'b1;
        else
          chan_cnt_reg[dev_chan_in] <= chan_cnt_reg[dev_chan_in] + 7'h01;
        if (dev_has_addr_in && !used_reg[dev_chan_in][dev_addr_in]) begin
          used_reg[dev_chan_in][dev_addr_in] <= 1'b1;
        end else if (auto_addr_en_in && free_addr != NO_FREE_ADDR) begin
          // Unaddressed, or a duplicate holder of a taken address
          used_reg[dev_chan_in][free_addr[5:0]] <= 1'b1;
          assign_valid_out <= 1'b1;
          assign_chan_out  <= dev_chan_in;
          assign_addr_out  <= free_addr[5:0];
          assign_dev_out   <= dev_number(free_addr[5:0]);
        end
      end
    end
  end

  // ==========================================================================
  // LEDs; init blink outranks test blink, which outranks steady fault
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ready_led_out  <= 1'b0;
      status_led_out <= 1'b0;
    end else begin
      ready_led_out <= supply_ok_in && mode_reg == LGPC_MODE_NORMAL && !test_enter;
      if (init_active_out)
        status_led_out <= fast_blink;
      else if (mode_reg == LGPC_MODE_TEST)
        status_led_out <= slow_blink;
      else
        status_led_out <= fault_short_in || fault_ballast_in || fault_lamp_in;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_mid_in_test;
    mode_reg == LGPC_MODE_TEST && mid_p && !bus_recover_in;
  endsequence

  prog_toggle_on_a: assert property (prog_btn_in && !prog_btn_d_reg && !prog_led_out |=> prog_led_out)
    else $error("prog LED not lit on press");
  fault_steady_a: assert property (!init_active_out && mode_reg == LGPC_MODE_NORMAL && fault_lamp_in
                                   |=> status_led_out)
    else $error("status LED dark on fault");
  init_start_a: assert property (download_in |=> init_active_out && init_start_out)
    else $error("init not started after download");
  overflow_hold_a: assert property (overflow_reg && init_active_out && !init_go |=> init_active_out)
    else $error("init ended despite overflow");
  test_entry_a: assert property (test_enter |=> test_mode_out && chan_a_on_out && !chan_b_on_out
                                 && !ready_led_out && discard_levels_out)
    else $error("test entry state wrong");
  chan_swap_a: assert property (mode_reg == LGPC_MODE_TEST && short_p && !mid_p && !test_leave
                                |=> chan_a_on_out != $past(chan_a_on_out))
    else $error("channels not swapped");
  test_exit_a: assert property (s_mid_in_test |=> !test_mode_out ##1 init_active_out)
    else $error("test exit sequence wrong");
  long_keep_a: assert property (long_p && !counting_reg && !test_enter && !test_leave
                                |=> count_req_out && $stable(mode_reg))
    else $error("long press changed mode");
  recover_end_a: assert property (mode_reg == LGPC_MODE_TEST && bus_recover_in |=> !test_mode_out && init_active_out)
    else $error("bus recovery did not end test");
  idle_end_a: assert property (idle_hit && !mid_p |=> !test_mode_out && $stable(chan_a_on_out))
    else $error("idle timeout wrong");
  dev_number_a: assert property (assign_valid_out |-> assign_dev_out == {1'b0, assign_addr_out} + 7'h01)
    else $error("device number not address plus one");
  auto_off_a: assert property (!auto_addr_en_in |=> !assign_valid_out)
    else $error("address assigned while disabled");
endmodule
`default_nettype wire

// [test/lgpc_gear_model.sv]
// Purpose: Scan engine and lighting gear on the far side of the panel logic.
// Assumes: One report per cycle; addressed gear is reported first.
// Notes:   Reports n_in devices on channel A after each start request.
`timescale 1ns/1ns
`default_nettype none
module lgpc_gear_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       start_in,
  input  wire logic [6:0] n_in,
  input  wire logic       pre_in,
  output logic            dev_valid_out,
  output logic            dev_chan_out,
  output logic            dev_has_addr_out,
  output logic [5:0]      dev_addr_out,
  output logic            scan_done_out
);
  logic [7:0] idx_reg;
  logic       run_reg;
  // ==========================================================================
  // Scan sequencer; n_in above 64 overflows one channel
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_reg <= 1'b0;
      idx_reg <= 8'h00;
    end else if (start_in) begin
      run_reg <= 1'b1;
      idx_reg <= 8'h00;
    end else if (run_reg) begin
      idx_reg <= idx_reg + 8'h01;
      if (idx_reg == {1'b0, n_in}) run_reg <= 1'b0;
    end
  end
  // Two gear share address 0 when pre_in is set
  assign dev_valid_out    = run_reg && (idx_reg < {1'b0, n_in});
  assign scan_done_out    = run_reg && (idx_reg == {1'b0, n_in});
  assign dev_chan_out     = 1'b0;
  assign dev_has_addr_out = pre_in && (idx_reg < 8'h02);
  // Unless dev_has_addr_out is set the address lines show the inverted scan index, which holds between scans
  assign dev_addr_out     = dev_has_addr_out ? 6'h00 : ~idx_reg[5:0];
endmodule
`default_nettype wire

// [test/test_lgpc_panel_ctrl.sv]
// Purpose: Self-checking bench for the panel control block.
// Assumes: Shortened timers from the hand-over values.
// Notes:   Random lengths and counts from one fixed seed.
`timescale 1ns/1ns
`default_nettype none
module test_lgpc_panel_ctrl;
  import lgpc_pkg::*;
  localparam int DEB = 4;
  logic clk = 0, srst = 1, pb = 0, ps = 0, sup = 0, fs = 0, fb = 0, fl = 0, tbt = 0;
  logic dl = 0, br = 0, cc = 0, ae = 1, pre = 0;
  logic [15:0] pa = 16'h0000, pao;
  logic [6:0] n = 7'h03, adv;
  logic prg, rdy, st, tm, ca, cb, dis, ia, is, cr, drd, av, ach, dv, dc, dh, sd;
  logic [7:0] refc;
  logic [5:0] aad, da;
  int fail_count = 0, num_checks = 0, exp_a = 0, asg = 0, dcnt = 0, i;
  // ==========================================================================
  // Clock and instances
  always #4 clk = ~clk;
  lgpc_panel_ctrl #(.DEB_CYC(DEB), .SHORT_LIM(20), .LONG_LIM(50), .IDLE_LIM(200), .SLOW_HALF(10),
    .FAST_HALF(3)) dut_u (.clk_in(clk), .srst_in(srst), .prog_btn_in(pb), .phys_set_in(ps),
    .phys_addr_in(pa), .supply_ok_in(sup), .fault_short_in(fs), .fault_ballast_in(fb),
    .fault_lamp_in(fl), .test_btn_in(tbt), .download_in(dl), .bus_recover_in(br),
    .count_cmd_in(cc), .auto_addr_en_in(ae), .dev_valid_in(dv), .dev_chan_in(dc),
    .dev_has_addr_in(dh), .dev_addr_in(da), .scan_done_in(sd), .prog_led_out(prg),
    .phys_addr_out(pao), .ready_led_out(rdy), .status_led_out(st), .test_mode_out(tm),
    .chan_a_on_out(ca), .chan_b_on_out(cb), .discard_levels_out(dis), .init_active_out(ia),
    .init_start_out(is), .count_req_out(cr), .ref_count_out(refc), .dev_ready_out(drd),
    .assign_valid_out(av), .assign_chan_out(ach), .assign_addr_out(aad), .assign_dev_out(adv));
  lgpc_gear_model gear_u (.clk_in(clk), .srst_in(srst), .start_in(is | cr), .n_in(n),
    .pre_in(pre), .dev_valid_out(dv), .dev_chan_out(dc), .dev_has_addr_out(dh),
    .dev_addr_out(da), .scan_done_out(sd));
  // ==========================================================================
  // Shared tasks
  task check(string nm, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask
  task complete_run;
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  // Bounded wait; running out counts as a mismatch
  task automatic wait_v(ref logic s, input logic v);
    int k;
    for (k = 0; k < 800 && s !== v; k++) cyc(1);
    if (k == 800) begin
      fail_count++;
      complete_run;
    end
  endtask
  task press(int k);
    tbt = 1;
    cyc(k);
    tbt = 0;
    cyc(DEB + 6);
  endtask
  // Length of one lit phase of the status LED
  task half(int e);
    int k;
    wait_v(st, 0);
    wait_v(st, 1);
    for (k = 0; k < 50 && st === 1; k++) cyc(1);
    check("half", 16'(k), 16'(e));
  endtask
  // Allocated addresses ascend from the first free one; read off the falling edge
  always @(negedge clk) begin
    if (is === 1) exp_a = int'(pre);
    if (dis === 1) dcnt++;
    if (av === 1) begin
      check("addr", 16'(aad), 16'(exp_a));
      check("dev", 16'(adv), 16'(exp_a + 1));
      check("chan", 16'(ach), 16'h0000);
      exp_a++;
      asg++;
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hBBA3644E));
    cyc(10);
    srst = 0;
    cyc(1);
    check("phys", pao, 16'hFFFF);
    check("accept", 16'(drd), 16'h0001);
    pulse(pb);
    cyc(2);
    check("prog", 16'(prg), 16'h0001);
    pa = 16'($urandom);
    pulse(ps);
    cyc(2);
    check("prog", 16'(prg), 16'h0000);
    check("phys", pao, pa);
    pulse(pb);
    cyc(2);
    pulse(pb);
    cyc(2);
    check("prog", 16'(prg), 16'h0000);
    sup = 1;
    cyc(3);
    check("ready", 16'(rdy), 16'h0001);
    sup = 0;
    cyc(3);
    check("ready", 16'(rdy), 16'h0000);
    sup = 1;
    n = 7'(1 + $urandom % 8);
    for (i = 0; i < 3; i++) begin
      {fs, fb, fl} = 3'(1 << i);
      cyc(3);
      check("fault", 16'(st), 16'h0001);
      {fs, fb, fl} = 3'h0;
      cyc(3);
    end
    check("init", 16'(ia), 16'h0001);
    wait_v(ia, 0);
    check("asg", 16'(asg), 16'(n));
    pre = 1;
    asg = 0;
    pulse(dl);
    cyc(2);
    wait_v(ia, 0);
    check("asg", 16'(asg), 16'(n - 1));
    {pre, ae, asg} = 0;
    pulse(br);
    cyc(2);
    wait_v(ia, 0);
    check("asg", 16'(asg), 16'h0000);
    ae = 1;
    n = 7'h41;
    pulse(br);
    cyc(150);
    check("init", 16'(ia), 16'h0001);
    // Overflowed init never ends, so the fast blink can be timed here
    half(3);
    n = 7'h03;
    pulse(br);
    cyc(2);
    wait_v(ia, 0);
    press(25 + $urandom % 20);
    check("test", {tm, ca, cb, rdy}, 16'h000C);
    half(10);
    press(8 + $urandom % 8);
    check("swap", {ca, cb}, 16'h0001);
    press(60);
    cyc(10);
    check("ref", 16'(refc), 16'h0003);
    n = 7'(1 + $urandom % 8);
    pulse(cc);
    cyc(15);
    check("ref", {tm, refc}, {8'h01, 1'b0, n});
    // Long scan keeps init running past the exit check
    n = 7'h10;
    press(30);
    check("exit", {tm, rdy, ia}, 16'h0003);
    wait_v(ia, 0);
    cyc(2);
    check("stat", 16'(st), 16'h0000);
    press(30);
    cyc(150);
    press(10);
    cyc(150);
    check("idle", 16'(tm), 16'h0001);
    cyc(80);
    check("idle", {tm, cb}, 16'h0001);
    wait_v(ia, 0);
    press(30);
    pulse(br);
    cyc(2);
    check("recov", {tm, ia}, 16'h0001);
    wait_v(ia, 0);
    check("disc", 16'(dcnt), 16'h0003);
    complete_run;
  end
endmodule
`default_nettype wire
